// [hdl/pats_seq.sv]
// What this block does
// - Convert pending pairs lowest input first.
// - Keep pending requests from all six input pairs.
// - Hold samples of at most four inputs.
// - Each input pair picks one of sixteen triggers.
// - Two 10-bit results per conversion, in one microsecond.
// - No sampling or converting during Sleep.
// - Converter works only with PLL clock selected.
// - Pin register chooses analog or digital per pin.
// - Status register shows conversion progress.
// - Both sample-and-holds of a pair fire together on the pair's trigger.
// - Pair trigger registers choose each pair's start event.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
module pats_seq
    import pats_pkg::*;
#(
    parameter int unsigned CYC = CONV_CYC
) (
    input wire logic i_clk, // System clock, 250 MHz.
    input wire logic i_rstn, // Asynchronous reset, active low.
    input wire logic [7:0] i_awaddr, // AXI write address.
    input wire logic i_awvalid, // AXI write address valid.
    output logic o_awready, // AXI write address ready.
    input wire logic [31:0] i_wdata, // AXI write data.
    input wire logic [3:0] i_wstrb, // AXI write byte strobes.
    input wire logic i_wvalid, // AXI write data valid.
    output logic o_wready, // AXI write data ready.
    output logic [1:0] o_bresp, // AXI write response.
    output logic o_bvalid, // AXI write response valid.
    input wire logic i_bready, // AXI write response ready.
    input wire logic [7:0] i_araddr, // AXI read address.
    input wire logic i_arvalid, // AXI read address valid.
    output logic o_arready, // AXI read address ready.
    output logic [31:0] o_rdata, // AXI read data.
    output logic [1:0] o_rresp, // AXI read response.
    output logic o_rvalid, // AXI read data valid.
    input wire logic i_rready, // AXI read data ready.
    input wire logic [NUM_TRIG_SRC-1:0] i_trig, // Trigger sources, rising edge.
    input wire logic i_sleep, // Device in Sleep mode.
    input wire logic [1:0] i_osc_source_select, // Oscillator source field.
    input wire logic [RES_W-1:0] i_code_a, // Even input code from the array.
    input wire logic [RES_W-1:0] i_code_b, // Odd input code from the array.
    output logic [NUM_INPUTS-1:0] o_sh_hold, // Sample-and-hold in hold.
    output logic [NUM_INPUTS-1:0] o_pin_analog, // Pin is an analog input.
    output logic o_conv_busy, // Converter working.
    output logic [2:0] o_conv_pair, // Pair on the converter.
    output logic o_irq // Interrupt, active high level.
);
    localparam int unsigned HOLD_PAIRS = HOLD_MAX_INPUTS / 2;

    typedef logic [NUM_PAIRS-1:0] pats_pairs_t;

    // Index of the lowest set bit; the caller checks for an empty vector.
    function automatic logic [2:0] lowest_pair(input pats_pairs_t v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_PAIRS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rd_data;
    logic [3:0] w_strb_q;
    logic have_aw_q, have_w_q, wr_en, wr_ok, rd_ok, on_q, start_q, run, core_busy, core_done;
    logic [15:0] base_q;
    logic [NUM_INPUTS-1:0] pcfg_q;
    logic [TRIG_SEL_W-1:0] trig_sel_q [NUM_PAIRS];
    logic [RES_W-1:0] res_q [NUM_INPUTS];
    logic [RES_W-1:0] core_res_a, core_res_b;
    logic [NUM_TRIG_SRC-1:0] trig_prev_q;
    logic [2:0] start_pair_q, core_pair, held_cnt;
    pats_pairs_t irq_stat_q, irq_en_q, pend_q, held, req;
    pats_pairs_t hold_set, done_mask, clr_mask, irq_stat_d;

    assign run = on_q && !i_sleep && (i_osc_source_select == OSC_SEL_PLL);

    always_comb begin
        for (int p = 0; p < NUM_PAIRS; p++) begin
            held[p] = o_sh_hold[2*p];
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_addr_q <= i_awaddr;
                have_aw_q <= 1'b1;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
                have_w_q <= 1'b1;
                o_wready <= 1'b0;
            end
            if (wr_en) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                have_aw_q <= 1'b0;
                have_w_q <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    assign wr_en = have_aw_q && have_w_q && !o_bvalid;

    assign wr_ok = aw_addr_q[7:2] <= OFS_IRQ_EN[7:2]
        || (aw_addr_q >= OFS_RES_BASE && aw_addr_q < OFS_RES_BASE + RES_SPAN);

    // Configuration registers written by software.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            on_q <= 1'b0;
            base_q <= BASE_RST;
            pcfg_q <= PCFG_RST;
            irq_en_q <= '0;
            for (int p = 0; p < NUM_PAIRS; p++) begin
                trig_sel_q[p] <= TRIG_SEL_RST;
            end
        end else if (wr_en) begin
            logic [31:0] cur;
            logic [7:0] a;
            logic [2:0] pr;
            cur = 32'h0;
            a = {aw_addr_q[7:2], 2'h0};
            pr = 3'h0;
            if (a == OFS_CTRL) begin
                cur[CTRL_ON_BIT] = on_q;
                cur = strb_merge(cur, w_data_q, w_strb_q);
                on_q <= cur[CTRL_ON_BIT];
            end else if (a == OFS_BASE) begin
                cur[15:0] = base_q;
                cur = strb_merge(cur, w_data_q, w_strb_q);
                base_q <= cur[15:0];
            end else if (a == OFS_PCFG) begin
                cur[NUM_INPUTS-1:0] = pcfg_q;
                cur = strb_merge(cur, w_data_q, w_strb_q);
                pcfg_q <= cur[NUM_INPUTS-1:0];
            end else if (a == OFS_CPC0 || a == OFS_CPC1 || a == OFS_CPC2) begin
                pr = 3'((a - OFS_CPC0) >> 1);
                cur[CPC_LO_LSB +: TRIG_SEL_W] = trig_sel_q[pr];
                cur[CPC_HI_LSB +: TRIG_SEL_W] = trig_sel_q[pr + 3'h1];
                cur = strb_merge(cur, w_data_q, w_strb_q);
                trig_sel_q[pr] <= cur[CPC_LO_LSB +: TRIG_SEL_W];
                trig_sel_q[pr + 3'h1] <= cur[CPC_HI_LSB +: TRIG_SEL_W];
            end else if (a == OFS_IRQ_EN) begin
                cur[NUM_PAIRS-1:0] = irq_en_q;
                cur = strb_merge(cur, w_data_q, w_strb_q);
                irq_en_q <= cur[NUM_PAIRS-1:0];
            end
        end
    end

    assign clr_mask = (wr_en && aw_addr_q[7:2] == OFS_IRQ_CLR[7:2] && w_strb_q[0])
        ? w_data_q[NUM_PAIRS-1:0] : '0;

    // Read channel: the answer comes one cycle after the address is taken.
    always_comb begin
        logic [7:0] a;
        logic [7:0] roff;
        a = {i_araddr[7:2], 2'h0};
        roff = a - OFS_RES_BASE;
        rd_data = 32'h0;
        rd_ok = 1'b1;
        if (a == OFS_CTRL) begin
            rd_data[CTRL_ON_BIT] = on_q;
        end else if (a == OFS_STAT) begin
            rd_data[STAT_PEND_LSB +: NUM_PAIRS] = pend_q;
            rd_data[STAT_HELD_LSB +: NUM_PAIRS] = held;
            rd_data[STAT_BUSY_BIT] = core_busy;
            rd_data[STAT_RUN_BIT] = run;
        end else if (a == OFS_BASE) begin
            rd_data[15:0] = base_q;
        end else if (a == OFS_PCFG) begin
            rd_data[NUM_INPUTS-1:0] = pcfg_q;
        end else if (a == OFS_CPC0 || a == OFS_CPC1 || a == OFS_CPC2) begin
            rd_data[CPC_LO_LSB +: TRIG_SEL_W] = trig_sel_q[3'((a - OFS_CPC0) >> 1)];
            rd_data[CPC_HI_LSB +: TRIG_SEL_W] = trig_sel_q[3'((a - OFS_CPC0) >> 1) + 3'h1];
        end else if (a == OFS_IRQ_STAT) begin
            rd_data[NUM_PAIRS-1:0] = irq_stat_q;
        end else if (a == OFS_IRQ_CLR) begin
            rd_data = 32'h0;
        end else if (a == OFS_IRQ_EN) begin
            rd_data[NUM_PAIRS-1:0] = irq_en_q;
        end else if (a >= OFS_RES_BASE && a < OFS_RES_BASE + RES_SPAN) begin
            rd_data[RES_W-1:0] = res_q[roff[5:2]];
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rd_data;
                o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // Trigger edges. A pair with no analog pin has nothing to sample.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_prev_q <= '0;
        end else begin
            trig_prev_q <= i_trig;
        end
    end

    always_comb begin
        logic [NUM_TRIG_SRC-1:0] rise;
        rise = i_trig & ~trig_prev_q;
        for (int p = 0; p < NUM_PAIRS; p++) begin
            req[p] = run && rise[trig_sel_q[p]] && (pcfg_q[2*p] || pcfg_q[2*p+1]);
        end
    end

    assign held_cnt = 3'($countones(held));

    // One pair enters hold per cycle, lowest pending first, while a hold slot is free.
    always_comb begin
        pats_pairs_t cand;
        cand = pend_q & ~held;
        hold_set = '0;
        if (run && cand != '0 && held_cnt < 3'(HOLD_PAIRS)) begin
            hold_set[lowest_pair(cand)] = 1'b1;
        end
    end

    assign done_mask = core_done ? pats_pairs_t'(1) << core_pair : '0;

    // A trigger landing on a pair in hold is kept pending for its next sample.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_q <= '0;
        end else if (!run) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~hold_set) | req;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sh_hold <= '0;
        end else if (!run) begin
            o_sh_hold <= '0;
        end else begin
            for (int p = 0; p < NUM_PAIRS; p++) begin
                if (hold_set[p]) begin
                    o_sh_hold[2*p +: 2] <= 2'h3;
                end else if (done_mask[p]) begin
                    o_sh_hold[2*p +: 2] <= 2'h0;
                end
            end
        end
    end

    // Start is held off on the done cycle so a finished pair is not converted twice.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            start_q <= 1'b0;
            start_pair_q <= 3'h0;
        end else begin
            start_q <= 1'b0;
            if (run && !core_busy && !core_done && !start_q && held != '0) begin
                start_q <= 1'b1;
                start_pair_q <= lowest_pair(held);
            end
        end
    end

    pats_conv_core #(.CYC(CYC), .PW(3)) u_core (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_abort(!run), .i_start(start_q),
        .i_pair(start_pair_q), .i_code_a(i_code_a), .i_code_b(i_code_b),
        .o_busy(core_busy), .o_done(core_done), .o_pair(core_pair),
        .o_res_a(core_res_a), .o_res_b(core_res_b)
    );

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                res_q[i] <= '0;
            end
        end else if (core_done) begin
            res_q[{core_pair, 1'b0}] <= core_res_a;
            res_q[{core_pair, 1'b1}] <= core_res_b;
        end
    end

    // Set wins over a clear in the same cycle.
    assign irq_stat_d = (irq_stat_q & ~clr_mask) | done_mask;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_q <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            o_irq <= |(irq_stat_d & irq_en_q);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pin_analog <= '0;
            o_conv_busy <= 1'b0;
            o_conv_pair <= 3'h0;
        end else begin
            o_pin_analog <= pcfg_q;
            o_conv_busy <= core_busy;
            o_conv_pair <= core_pair;
        end
    end
endmodule

// [hdl/pats_pkg.sv]
package pats_pkg;
    // Clock and conversion timing.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned CONV_TIME_NS = 1000;
    // Longest allowed time for two results, so the count rounds down.
    localparam int unsigned CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;

    // Converter geometry.
    localparam int unsigned NUM_INPUTS = 12;
    localparam int unsigned NUM_PAIRS = 6;
    localparam int unsigned NUM_TRIG_SRC = 16;
    localparam int unsigned TRIG_SEL_W = 4;
    localparam int unsigned HOLD_MAX_INPUTS = 4;
    localparam int unsigned RES_W = 10;

    // Oscillator source code that selects the PLL.
    localparam logic [1:0] OSC_SEL_PLL = 2'h1;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_BASE = 8'h08;
    localparam logic [7:0] OFS_PCFG = 8'h0c;
    localparam logic [7:0] OFS_CPC0 = 8'h10;
    localparam logic [7:0] OFS_CPC1 = 8'h14;
    localparam logic [7:0] OFS_CPC2 = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN = 8'h24;
    localparam logic [7:0] OFS_RES_BASE = 8'h40;
    localparam logic [7:0] RES_SPAN = 8'h30;

    // Field positions.
    localparam int unsigned CTRL_ON_BIT = 0;
    localparam int unsigned STAT_PEND_LSB = 0;
    localparam int unsigned STAT_HELD_LSB = 8;
    localparam int unsigned STAT_BUSY_BIT = 16;
    localparam int unsigned STAT_RUN_BIT = 17;
    localparam int unsigned CPC_LO_LSB = 0;
    localparam int unsigned CPC_HI_LSB = 8;

    // Reset values.
    localparam logic [15:0] BASE_RST = 16'h0000;
    localparam logic [11:0] PCFG_RST = 12'h000;
    localparam logic [3:0] TRIG_SEL_RST = 4'h0;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hdl/pats_conv_core.sv]
module pats_conv_core
    import pats_pkg::*;
#(
    parameter int unsigned CYC = CONV_CYC,
    parameter int unsigned PW = 3
) (
    input wire logic i_clk, // System clock.
    input wire logic i_rstn, // Asynchronous reset, active low.
    input wire logic i_abort, // Drop any conversion at once.
    input wire logic i_start, // Start converting one held pair.
    input wire logic [PW-1:0] i_pair, // Pair to convert.
    input wire logic [RES_W-1:0] i_code_a, // Code of the even input at the end.
    input wire logic [RES_W-1:0] i_code_b, // Code of the odd input at the end.
    output logic o_busy, // Conversion under way.
    output logic o_done, // One-cycle pulse, results valid.
    output logic [PW-1:0] o_pair, // Pair on the converter.
    output logic [RES_W-1:0] o_res_a, // Even input result.
    output logic [RES_W-1:0] o_res_b // Odd input result.
);
    localparam int unsigned CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic [CW-1:0] cnt_q;

    // Both inputs of the pair are resolved together, inside one conversion time.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            cnt_q <= '0;
            o_pair <= '0;
            o_res_a <= '0;
            o_res_b <= '0;
        end else if (i_abort) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            cnt_q <= '0;
        end else begin
            o_done <= 1'b0;
            if (!o_busy && i_start) begin
                o_busy <= 1'b1;
                cnt_q <= '0;
                o_pair <= i_pair;
            end else if (o_busy) begin
                if (cnt_q == LAST) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    o_res_a <= i_code_a;
                    o_res_b <= i_code_b;
                end else begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    end
endmodule

// [verif/pats_pwm_model.sv]
module pats_pwm_model (
    input wire logic i_clk, // System clock.
    input wire logic [15:0] i_fire, // Sources to pulse.
    input wire logic [2:0] i_pair, // Pair on the converter.
    output logic [15:0] o_trig, // Trigger lines.
    output logic [9:0] o_code_a, // Even input code.
    output logic [9:0] o_code_b // Odd input code.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] f_q = 16'h0000;
    logic [15:0] d_q = 16'h0000;
    // Stretch each fire to two cycles.
    always_ff @(posedge i_clk) begin
        f_q <= i_fire;
        d_q <= f_q;
    end
    assign o_trig = f_q | d_q;
    assign o_code_a = {i_pair, 7'h2a};
    assign o_code_b = {i_pair, 7'h55};
endmodule

// [verif/pats_seq_props.sv]
module pats_seq_props
    import pats_pkg::*;
#(
    parameter int unsigned CYC = CONV_CYC
) (
    input wire logic i_clk, // Clock.
    input wire logic i_rstn, // Reset, active low.
    input wire logic i_bready, // B ready.
    input wire logic i_rready, // R ready.
    input wire logic i_sleep, // Sleep.
    input wire logic [1:0] i_osc_source_select, // Oscillator field.
    input wire logic o_bvalid, // B valid.
    input wire logic o_rvalid, // R valid.
    input wire logic [31:0] o_rdata, // Read data.
    input wire logic [NUM_INPUTS-1:0] o_sh_hold, // Held inputs.
    input wire logic [NUM_INPUTS-1:0] o_pin_analog, // Analog pins.
    input wire logic o_conv_busy, // Converter busy.
    input wire logic [2:0] o_conv_pair, // Pair converted.
    input wire logic o_irq // Interrupt.
);
    logic [8:0] busy_cnt_q;
    logic [NUM_INPUTS-1:0] pair_an;
    // A pair may be sampled when either of its two pins is analog.
    assign pair_an = o_pin_analog | ((o_pin_analog >> 1) & 12'h555)
        | ((o_pin_analog << 1) & 12'haaa);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_cnt_q <= 9'h000;
        end else begin
            busy_cnt_q <= o_conv_busy ? busy_cnt_q + 9'h001 : 9'h000;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    hold_limit_a: assert property ($countones(o_sh_hold) <= HOLD_MAX_INPUTS)
        else $error("too many inputs held");
    hold_pair_a: assert property (((o_sh_hold ^ (o_sh_hold >> 1)) & 12'h555) == 12'h000)
        else $error("pair halves held apart");
    conv_time_a: assert property (o_conv_busy |-> busy_cnt_q < CYC)
        else $error("conversion too long");
    conv_len_a: assert property ($fell(o_conv_busy) && !i_sleep
        && i_osc_source_select == OSC_SEL_PLL |-> busy_cnt_q == 9'(CYC))
        else $error("conversion length wrong");
    sleep_idle_a: assert property (i_sleep [*4] |-> o_sh_hold == 12'h000 && !o_conv_busy)
        else $error("activity in sleep");
    pll_idle_a: assert property ((i_osc_source_select != OSC_SEL_PLL) [*4]
        |-> o_sh_hold == 12'h000 && !o_conv_busy)
        else $error("activity without pll");
    held_conv_a: assert property (o_conv_busy && !$fell(o_sh_hold[{o_conv_pair, 1'b0}])
        |-> o_sh_hold[{o_conv_pair, 1'b0}])
        else $error("converting unheld pair");
    pair_stable_a: assert property (o_conv_busy && $past(o_conv_busy) |-> $stable(o_conv_pair))
        else $error("pair changed mid conversion");
    analog_only_a: assert property ((o_sh_hold & ~$past(o_sh_hold) & ~pair_an) == 12'h000)
        else $error("digital pin sampled");
    bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("write response dropped");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    conv_c: cover property ($rose(o_conv_busy));
    four_c: cover property ($countones(o_sh_hold) == 4);
    irq_c: cover property ($rose(o_irq));
endmodule
bind pats_seq pats_seq_props #(.CYC(CYC)) i_props (.i_clk, .i_rstn, .i_bready, .i_rready,
    .i_sleep, .i_osc_source_select, .o_bvalid, .o_rvalid, .o_rdata, .o_sh_hold,
    .o_pin_analog, .o_conv_busy, .o_conv_pair, .o_irq);

// [verif/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pats_pkg::*;
    localparam int unsigned TCYC = 4;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_sleep = 1'b0, busy_q = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_conv_busy, o_irq;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, v;
    logic [3:0] i_wstrb = 4'hf;
    logic [1:0] i_osc_source_select = OSC_SEL_PLL, o_bresp, o_rresp, rs;
    logic [15:0] fire = 16'h0000, i_trig;
    logic [9:0] i_code_a, i_code_b;
    logic [11:0] o_sh_hold, o_pin_analog;
    logic [2:0] o_conv_pair;
    logic [2:0] order[$];
    int bad_count = 0, comparisons = 0, cycles = 0;
    logic [7:0] ra [9] = '{OFS_CTRL, OFS_BASE, OFS_PCFG, OFS_CPC1, OFS_IRQ_EN, OFS_STAT,
        OFS_IRQ_CLR, 8'h28, 8'h70};
    logic [31:0] rx [9] = '{32'h1, 32'hffff, 32'hfff, 32'hf0f, 32'h3f, 32'h2_0000, 32'h0,
        32'h0, 32'h0};
    logic [1:0] rr [9] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY,
        RESP_OKAY, RESP_SLVERR, RESP_SLVERR};
    pats_seq #(.CYC(TCYC)) i_dut (.i_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_trig, .i_sleep,
        .i_osc_source_select, .i_code_a, .i_code_b, .o_sh_hold, .o_pin_analog, .o_conv_busy,
        .o_conv_pair, .o_irq);
    pats_pwm_model i_pwm (.i_clk, .i_fire(fire), .i_pair(o_conv_pair), .o_trig(i_trig),
        .o_code_a(i_code_a), .o_code_b(i_code_b));
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge i_clk) begin
        busy_q <= o_conv_busy;
        if (o_conv_busy && !busy_q) order.push_back(o_conv_pair);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Ready moves only on edges, so a look just after one predicts the take.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw;
        ha = 0;
        hw = 0;
        {i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, d, 2'b11};
        while (!(ha && hw)) begin
            #1;
            ha = ha | o_awready;
            hw = hw | o_wready;
            @(posedge i_clk);
            if (ha) i_awvalid <= 1'b0;
            if (hw) i_wvalid <= 1'b0;
        end
        i_bready <= 1'b1;
        do begin
            #1;
            ha = o_bvalid;
            r = o_bresp;
            @(posedge i_clk);
        end while (!ha);
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic h;
        {i_araddr, i_arvalid} <= {a, 1'b1};
        do begin
            #1;
            h = o_arready;
            @(posedge i_clk);
        end while (!h);
        {i_arvalid, i_rready} <= 2'b01;
        do begin
            #1;
            h = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_clk);
        end while (!h);
        i_rready <= 1'b0;
    endtask
    task automatic pulse(input logic [15:0] p);
        fire <= p;
        @(posedge i_clk);
        fire <= 16'h0000;
    endtask
    task automatic waitst(input logic [5:0] e);
        logic [31:0] s;
        logic [1:0] r;
        s = 32'h0;
        for (int n = 0; n < 80 && s[5:0] != e; n++) rd(OFS_IRQ_STAT, s, r);
        chk("irq_stat", s, {26'h0, e});
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        chk("reset", {o_awready, o_wready, o_arready, o_bvalid, o_rvalid, o_irq, o_conv_busy,
            o_sh_hold, o_pin_analog}, 31'h7000_0000);
        for (int i = 0; i < 9; i++) begin
            wr(ra[i], 32'hdead_ffff, rs);
            chk("bresp", 32'(rs), 32'(rr[i]));
            rd(ra[i], v, rs);
            chk("rdata", v, rx[i]);
            chk("rresp", 32'(rs), 32'(rr[i]));
        end
        chk("pins", 32'(o_pin_analog), 32'hfff);
        wr(OFS_PCFG, 32'h3, rs);
        wr(OFS_IRQ_EN, 32'h0, rs);
        wr(OFS_CTRL, 32'h1, rs);
        for (int s = 0; s < 16; s++) begin
            wr(OFS_CPC0, 32'(s), rs);
            pulse(~(16'h0001 << s));
            repeat (6) @(posedge i_clk);
            rd(OFS_STAT, v, rs);
            chk("stray", v & 32'h3f3f, 32'h0);
            pulse(16'h0001 << s);
            waitst(6'h01);
            chk("masked", 32'(o_irq), 32'h0);
            rd(OFS_RES_BASE + 8'h04, v, rs);
            chk("res_odd", v, 32'h055);
            wr(OFS_IRQ_CLR, 32'h1, rs);
        end
        wr(OFS_PCFG, 32'hfff, rs);
        wr(OFS_CPC0, 32'h0100, rs);
        wr(OFS_CPC1, 32'h0302, rs);
        wr(OFS_CPC2, 32'h0504, rs);
        wr(OFS_IRQ_EN, 32'h3f, rs);
        order.delete();
        pulse(16'h003f);
        waitst(6'h3f);
        chk("count", 32'(order.size()), 32'h6);
        foreach (order[i]) chk("order", 32'(order[i]), 32'(i));
        chk("irq", 32'(o_irq), 32'h1);
        for (int i = 0; i < 12; i++) begin
            rd(OFS_RES_BASE + 8'(4 * i), v, rs);
            chk("result", v, {22'h0, 3'(i / 2), (i % 2) ? 7'h55 : 7'h2a});
        end
        wr(OFS_IRQ_CLR, 32'h3f, rs);
        repeat (2) @(posedge i_clk);
        chk("irq_clr", 32'(o_irq), 32'h0);
        for (int k = 0; k < 3; k++) begin
            if (k == 0) i_sleep <= 1'b1;
            if (k == 1) i_osc_source_select <= 2'h2;
            if (k == 2) wr(OFS_CTRL, 32'h0, rs);
            pulse(16'h003f);
            repeat (10) @(posedge i_clk);
            rd(OFS_STAT, v, rs);
            chk("idle", v & 32'h3f3f, 32'h0);
            chk("hold", 32'(o_sh_hold), 32'h0);
            rd(OFS_IRQ_STAT, v, rs);
            chk("no_result", v, 32'h0);
            i_sleep <= 1'b0;
            i_osc_source_select <= OSC_SEL_PLL;
            wr(OFS_CTRL, 32'h1, rs);
        end
        pulse(16'h0001);
        for (int n = 0; n < 20 && !o_conv_busy; n++) @(posedge i_clk);
        i_sleep <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        chk("abort", {o_conv_busy, o_sh_hold}, 32'h0);
        @(posedge i_clk);
        i_sleep <= 1'b0;
        repeat (TCYC + 8) @(posedge i_clk);
        rd(OFS_IRQ_STAT, v, rs);
        chk("abort_res", v, 32'h0);
        pulse(16'h0001);
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("mid_reset", {o_conv_busy, o_sh_hold, o_awready}, 32'h1);
        @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        rd(OFS_PCFG, v, rs);
        chk("pcfg_rst", v, 32'(PCFG_RST));
        summarize();
    end
endmodule
